/* File: hw/rsc_top.sv */
// reset source controller: cause detection, flags, start-up timing, axi4-lite registers
//
// Added by the designer: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
module rsc_top
  import rsc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic porDetect,
  input wire logic extResetPin_n,
  input wire logic lowVoltageReset,
  input wire logic watchdogOverflow,
  input wire logic coreSleeping,
  input wire logic haltExec,
  input wire logic clrWdtExec,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [DATA_W/8-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output rsc_init_t rstCtl,
  output rsc_cause_t resetCause,
  output rsc_flags_t flags,
  output logic irq
);
  rsc_state_t state;
  rsc_state_t next_state;
  rsc_cause_t next_cause;
  rsc_clksrc_t ctrlClkSrc;
  logic ctrlShortSst;
  logic [2:0] pinSync;
  logic srcPor;
  logic srcPin;
  logic sstStart;
  logic sstBusy;
  logic sstDone;
  logic shortAllowed;
  logic causeEntry;
  logic fullReset;
  logic [NUM_EVENTS-1:0] evStatus;
  logic [NUM_EVENTS-1:0] evEnable;
  logic [NUM_EVENTS-1:0] evSet;
  logic [NUM_EVENTS-1:0] evClr;
  logic [ADDR_W-1:0] awAddrQ;
  logic [DATA_W-1:0] wDataQ;
  logic [DATA_W/8-1:0] wStrbQ;
  logic wrEn;
  logic wrMapped;

  // pins are asynchronous; the pin reset idles high
  rsc_sync #(
    .W(3),
    .RST_VAL(3'b010)
  ) u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .d({porDetect, extResetPin_n, lowVoltageReset}),
    .q(pinSync)
  );

  assign srcPor = pinSync[2];
  assign srcPin = ~pinSync[1] | pinSync[0];

  // short start-up only for rc clock sources
  assign shortAllowed = ctrlShortSst &&
      (ctrlClkSrc == CLK_EXTERNAL_RC || ctrlClkSrc == CLK_INTERNAL_RC);

  rsc_startup_timer #(
    .LONG_CYCLES(SST_LONG_CYCLES),
    .SHORT_CYCLES(SST_SHORT_CYCLES),
    .CNT_W(SST_W)
  ) u_sst (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .start(sstStart),
    .abort(state != ST_START),
    .shortMode(shortAllowed),
    .busy(sstBusy),
    .done(sstDone)
  );

  // cause selection; power-on beats pin/low-voltage beats watchdog
  always_comb begin
    next_state = state;
    next_cause = resetCause;
    unique case (state)
      ST_RUN: begin
        if (srcPor) begin
          next_state = ST_HOLD;
          next_cause = CAUSE_POWER_ON;
        end else if (srcPin) begin
          next_state = ST_HOLD;
          next_cause = CAUSE_PIN_OR_LOW_VOLTAGE;
        end else if (watchdogOverflow) begin
          next_state = ST_START;
          next_cause = coreSleeping ? CAUSE_WATCHDOG_SLEEP : CAUSE_WATCHDOG_RUN;
        end
      end
      ST_HOLD: begin
        if (srcPor) begin
          next_cause = CAUSE_POWER_ON;
        end else if (!srcPin) begin
          next_state = ST_START;
        end
      end
      ST_START: begin
        if (srcPor) begin
          next_state = ST_HOLD;
          next_cause = CAUSE_POWER_ON;
        end else if (srcPin) begin
          next_state = ST_HOLD;
          if (resetCause != CAUSE_POWER_ON) begin
            next_cause = CAUSE_PIN_OR_LOW_VOLTAGE;
          end
        end else if (sstDone) begin
          next_state = ST_RUN;
        end
      end
    endcase
  end

  // controller reset behaves as a power-on event
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state <= ST_HOLD;
      resetCause <= CAUSE_POWER_ON;
      sstStart <= 1'b0;
    end else begin
      state <= next_state;
      resetCause <= next_cause;
      sstStart <= (next_state == ST_START) && (state != ST_START);
    end
  end

  // a watchdog reset while running goes through the same sequence as a pin reset
  assign fullReset = (next_state != ST_RUN) && (next_cause != CAUSE_WATCHDOG_SLEEP);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rstCtl <= '{coreHold: 1'b1, pcClear: 1'b1, spToTop: 1'b1, spToZero: 1'b0,
                  intDisable: 1'b1, timerOff: 1'b1, prescalerClear: 1'b1,
                  portsInput: 1'b1, watchdogClear: 1'b1, wakeCore: 1'b0};
    end else begin
      rstCtl <= '0;
      if (fullReset) begin
        rstCtl.coreHold <= 1'b1;
        rstCtl.pcClear <= 1'b1;
        rstCtl.spToTop <= 1'b1;
        rstCtl.intDisable <= 1'b1;
        rstCtl.timerOff <= 1'b1;
        rstCtl.prescalerClear <= 1'b1;
        rstCtl.portsInput <= 1'b1;
        rstCtl.watchdogClear <= 1'b1;
      end
      // sleeping core keeps everything but pc and sp; it resumes at zero
      if (state == ST_START && sstDone && resetCause == CAUSE_WATCHDOG_SLEEP) begin
        rstCtl.pcClear <= 1'b1;
        rstCtl.spToZero <= 1'b1;
        rstCtl.wakeCore <= 1'b1;
      end
    end
  end

  // status flags; hardware reset events are applied last so they win
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      flags <= '0;
    end else begin
      if (clrWdtExec) begin
        flags.watchdogTimeoutFlag <= 1'b0;
        flags.powerdownFlag <= 1'b0;
      end
      if (haltExec) begin
        flags.watchdogTimeoutFlag <= 1'b0;
        flags.powerdownFlag <= 1'b1;
      end
      // pin or low-voltage entry writes nothing here, leaving both flags
      if (next_state == ST_HOLD && next_cause == CAUSE_POWER_ON) begin
        flags.watchdogTimeoutFlag <= 1'b0;
        flags.powerdownFlag <= 1'b0;
      end else if (state == ST_RUN && next_state == ST_START) begin
        flags.watchdogTimeoutFlag <= 1'b1;
        if (next_cause == CAUSE_WATCHDOG_SLEEP) begin
          flags.powerdownFlag <= 1'b1;
        end
      end
    end
  end

  // one event per reset entry or cause upgrade
  assign causeEntry = (state == ST_RUN && next_state != ST_RUN) ||
      (state != ST_RUN && next_cause != resetCause);
  assign evSet = causeEntry ? (NUM_EVENTS'(1) << next_cause) : '0;
  assign evClr = (wrEn && awAddrQ == REG_EVCLR && wStrbQ[0]) ?
      wDataQ[NUM_EVENTS-1:0] : '0;

  for (genvar i = 0; i < NUM_EVENTS; i++) begin : g_event
    always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
        evStatus[i] <= 1'b0;
      end else if (evSet[i]) begin
        evStatus[i] <= 1'b1;
      end else if (evClr[i]) begin
        evStatus[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(evStatus & evEnable);
    end
  end

  // axi4-lite write: address and data taken in either order, one write at a time
  assign wrEn = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wrMapped = (awAddrQ == REG_CTRL) || (awAddrQ == REG_STATUS) ||
      (awAddrQ == REG_EVENT) || (awAddrQ == REG_EVCLR) || (awAddrQ == REG_EVEN);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      awAddrQ <= '0;
      wDataQ <= '0;
      wStrbQ <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        awAddrQ <= {s_axi_awaddr[ADDR_W-1:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wDataQ <= s_axi_wdata;
        wStrbQ <= s_axi_wstrb;
      end
      if (wrEn) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrMapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // control register settings take effect at the next start-up timer load; event enables act on irq from the next edge
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ctrlClkSrc <= rsc_clksrc_t'(CTRL_RESET[CTRL_CLKSRC_LSB +: 2]);
      ctrlShortSst <= CTRL_RESET[CTRL_SHORT_BIT];
      evEnable <= EVEN_RESET;
    end else if (wrEn && wStrbQ[0]) begin
      if (awAddrQ == REG_CTRL) begin
        ctrlClkSrc <= rsc_clksrc_t'(wDataQ[CTRL_CLKSRC_LSB +: 2]);
        ctrlShortSst <= wDataQ[CTRL_SHORT_BIT];
      end
      if (awAddrQ == REG_EVEN) begin
        evEnable <= wDataQ[NUM_EVENTS-1:0];
      end
    end
  end

  // axi4-lite read, one cycle after the address is taken
  function automatic logic [DATA_W-1:0] readReg(input logic [ADDR_W-1:0] addr);
    logic [DATA_W-1:0] v;
    v = '0;
    unique case ({addr[ADDR_W-1:2], 2'b00})
      REG_CTRL: begin
        v[CTRL_CLKSRC_LSB +: 2] = ctrlClkSrc;
        v[CTRL_SHORT_BIT] = ctrlShortSst;
      end
      REG_STATUS: begin
        v[STATUS_TO_BIT] = flags.watchdogTimeoutFlag;
        v[STATUS_PDF_BIT] = flags.powerdownFlag;
        v[STATUS_CAUSE_LSB +: 2] = resetCause;
        v[STATUS_BUSY_BIT] = (state != ST_RUN) || sstBusy;
      end
      REG_EVENT: v[NUM_EVENTS-1:0] = evStatus;
      REG_EVEN: v[NUM_EVENTS-1:0] = evEnable;
      default: v = '0;
    endcase
    return v;
  endfunction

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= readReg(s_axi_araddr);
      s_axi_rresp <= ({s_axi_araddr[ADDR_W-1:2], 2'b00} > REG_EVEN) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule

/* File: hw/rsc_pkg.sv */
// constants, field layouts and types shared by the reset source controller
package rsc_pkg;
  // axi4-lite register map, byte addresses
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] REG_CTRL = 5'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS = 5'h04;
  localparam logic [ADDR_W-1:0] REG_EVENT = 5'h08;
  localparam logic [ADDR_W-1:0] REG_EVCLR = 5'h0c;
  localparam logic [ADDR_W-1:0] REG_EVEN = 5'h10;

  // control register fields
  localparam int CTRL_CLKSRC_LSB = 0;
  localparam int CTRL_SHORT_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;

  // status register fields
  localparam int STATUS_TO_BIT = 0;
  localparam int STATUS_PDF_BIT = 1;
  localparam int STATUS_CAUSE_LSB = 2;
  localparam int STATUS_BUSY_BIT = 4;

  // event bits, one per reset cause, indexed by cause code
  localparam int NUM_EVENTS = 4;
  localparam logic [NUM_EVENTS-1:0] EVEN_RESET = 4'h0;

  // start-up timer lengths in system clock cycles
  localparam int SST_LONG_CYCLES = 1024;
  localparam int SST_SHORT_CYCLES = 2;
  localparam int SST_W = 11;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    CLK_EXTERNAL_RC = 2'h0,
    CLK_INTERNAL_RC = 2'h1,
    CLK_HIGH_FREQ_CRYSTAL = 2'h2,
    CLK_LOW_FREQ_CRYSTAL = 2'h3
  } rsc_clksrc_t;

  // priority order: lower code wins
  typedef enum logic [1:0] {
    CAUSE_POWER_ON = 2'h0,
    CAUSE_PIN_OR_LOW_VOLTAGE = 2'h1,
    CAUSE_WATCHDOG_RUN = 2'h2,
    CAUSE_WATCHDOG_SLEEP = 2'h3
  } rsc_cause_t;

  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_HOLD = 3'b010,
    ST_START = 3'b100
  } rsc_state_t;

  // initialisation controls towards core and peripherals
  typedef struct packed {
    logic coreHold;
    logic pcClear;
    logic spToTop;
    logic spToZero;
    logic intDisable;
    logic timerOff;
    logic prescalerClear;
    logic portsInput;
    logic watchdogClear;
    logic wakeCore;
  } rsc_init_t;

  typedef struct packed {
    logic watchdogTimeoutFlag;
    logic powerdownFlag;
  } rsc_flags_t;
endpackage

/* File: hw/rsc_sync.sv */
// two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module rsc_sync
  import rsc_pkg::*;
#(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      meta <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

/* File: hw/rsc_startup_timer.sv */
// start-up timer: counts a long or short delay after a load pulse
`timescale 1ns/1ps
module rsc_startup_timer
  import rsc_pkg::*;
#(
  parameter int LONG_CYCLES = SST_LONG_CYCLES,
  parameter int SHORT_CYCLES = SST_SHORT_CYCLES,
  parameter int CNT_W = SST_W
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic abort,
  input wire logic shortMode,
  output logic busy,
  output logic done
);
  logic [CNT_W-1:0] count;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      count <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        busy <= 1'b1;
        count <= shortMode ? CNT_W'(SHORT_CYCLES - 1) : CNT_W'(LONG_CYCLES - 1);
      end else if (abort) begin
        busy <= 1'b0;
      end else if (busy) begin
        if (count == '0) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          count <= count - CNT_W'(1);
        end
      end
    end
  end
endmodule

/* File: tb/rsc_top_assertions.sv */
// port-level checks of the reset source controller
`timescale 1ns/1ps
module rsc_top_assertions
  import rsc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic watchdogOverflow,
  input wire logic coreSleeping,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire rsc_init_t rstCtl,
  input wire rsc_cause_t resetCause,
  input wire rsc_flags_t flags
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // a time-out during the sleep wake-up timer is ignored, so it must not count either
  logic sleepSeq;
  always_ff @(posedge ref_clk) begin
    if (!rst_n || rstCtl.coreHold || rstCtl.wakeCore) begin
      sleepSeq <= 1'b0;
    end else if (watchdogOverflow && coreSleeping) begin
      sleepSeq <= 1'b1;
    end
  end
  // a time-out counts only outside hold, whether the core runs or sleeps
  wire runWd = watchdogOverflow && !rstCtl.coreHold && !sleepSeq;

  por_clear_a: assert property ($rose(rst_n) |->
    flags == 2'b00 && resetCause == CAUSE_POWER_ON) else $error("flags not clear on power-on");
  wd_run_a: assert property (runWd && !coreSleeping |=>
    flags.watchdogTimeoutFlag && flags.powerdownFlag == $past(flags.powerdownFlag)
    && rstCtl.coreHold && resetCause == CAUSE_WATCHDOG_RUN) else $error("running time-out");
  wd_sleep_a: assert property (runWd && coreSleeping |=>
    flags == 2'b11 && resetCause == CAUSE_WATCHDOG_SLEEP) else $error("sleep time-out flags");
  sleep_keep_a: assert property (resetCause == CAUSE_WATCHDOG_SLEEP |->
    !rstCtl.coreHold && !rstCtl.intDisable && !rstCtl.timerOff) else $error("sleep reset too wide");
  wake_pulse_a: assert property (rstCtl.wakeCore |->
    rstCtl.pcClear && rstCtl.spToZero ##1 !rstCtl.wakeCore) else $error("wake pulse wrong");
  pin_keep_a: assert property ($changed(resetCause) &&
    resetCause == CAUSE_PIN_OR_LOW_VOLTAGE |-> $stable(flags)) else $error("pin reset hit flags");
  init_set_a: assert property (rstCtl.coreHold |->
    rstCtl.pcClear && rstCtl.spToTop && rstCtl.intDisable && rstCtl.timerOff
    && rstCtl.prescalerClear && rstCtl.portsInput && rstCtl.watchdogClear)
    else $error("init controls missing");
  rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");

  cover property (runWd && coreSleeping);
  cover property ($rose(rstCtl.wakeCore));
  cover property (resetCause == CAUSE_PIN_OR_LOW_VOLTAGE);
endmodule

bind rsc_top rsc_top_assertions rsc_top_assertions_inst (.ref_clk, .rst_n,
  .watchdogOverflow, .coreSleeping, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .rstCtl, .resetCause, .flags);

/* File: tb/rsc_core_model.sv */
// core stand-in: program counter and sleep state under the reset controls
`timescale 1ns/1ps
module rsc_core_model
  import rsc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sleepCmd,
  input wire rsc_init_t rstCtl,
  output logic coreSleeping,
  output logic [7:0] pc
);
  // pc only runs while awake, so a wake from zero shows as a small count
  always_ff @(posedge ref_clk) begin
    if (rstCtl.coreHold || rstCtl.pcClear) begin
      pc <= 8'h00;
    end else if (!coreSleeping) begin
      pc <= pc + 8'h01;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rstCtl.coreHold || rstCtl.wakeCore) begin
      coreSleeping <= 1'b0;
    end else if (sleepCmd) begin
      coreSleeping <= 1'b1;
    end
  end
endmodule

/* File: tb/tb.sv */
// self-checking bench: reset causes, flags, start-up timing, registers
`timescale 1ns/1ps
module tb
  import rsc_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic porDetect = 1'b0;
  logic extResetPin_n = 1'b1;
  logic lowVoltageReset = 1'b0;
  logic watchdogOverflow = 1'b0;
  logic haltExec = 1'b0;
  logic clrWdtExec = 1'b0;
  logic sleepCmd = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0;
  logic [ADDR_W-1:0] s_axi_araddr = '0;
  logic [DATA_W-1:0] s_axi_wdata = '0;
  logic [DATA_W/8-1:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_rresp;
  logic [1:0] s_axi_bresp;
  logic [1:0] br;
  logic [1:0] rr;
  logic [DATA_W-1:0] s_axi_rdata;
  logic [DATA_W-1:0] rd;
  logic irq;
  logic coreSleeping;
  logic [7:0] pc;
  rsc_init_t rstCtl;
  rsc_cause_t resetCause;
  rsc_flags_t flags;
  int failures = 0;
  int cmp_count = 0;
  int n;

  always #2.5 ref_clk = ~ref_clk;

  rsc_top rsc_top_inst (.ref_clk, .rst_n, .porDetect, .extResetPin_n, .lowVoltageReset,
    .watchdogOverflow, .coreSleeping, .haltExec, .clrWdtExec, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .rstCtl, .resetCause, .flags, .irq);
  rsc_core_model rsc_core_model_inst (.ref_clk, .sleepCmd, .rstCtl, .coreSleeping, .pc);

  task automatic give_verdict();
    if (failures == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // starts one edge late so a strobe never toggles twice in a step
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    logic pa;
    logic pw;
    @(posedge ref_clk);
    pa = 1'b1;
    pw = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (pa || pw) begin
      @(posedge ref_clk);
      if (pa && s_axi_awready) begin
        pa = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (pw && s_axi_wready) begin
        pw = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge ref_clk); while (!s_axi_bvalid);
    br = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rdr(input logic [ADDR_W-1:0] a);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge ref_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge ref_clk); while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic holdLen();
    n = 0;
    repeat (10) if (!rstCtl.coreHold) @(posedge ref_clk);
    while (rstCtl.coreHold) begin
      @(posedge ref_clk);
      n++;
    end
  endtask

  task automatic state(input logic [3:0] exp);
    chk(32'({resetCause, flags}), 32'(exp));
  endtask

  // hold length in edges; sync, load and release add a few edges to the timer count
  task automatic lenChk(input int l);
    chk(32'(n >= l && n <= l + 10), 32'h1);
  endtask

  initial begin
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    holdLen();
    lenChk(SST_LONG_CYCLES);
    state({CAUSE_POWER_ON, 2'b00});
    rdr(REG_CTRL);
    chk(rd, 32'h0);
    rdr(REG_EVEN);
    chk(rd, 32'h0);
    rdr(5'h14);
    chk(32'(rr), 32'(RESP_SLVERR));
    // strobe off: the write is answered but must not land
    s_axi_wstrb <= 4'h0;
    wr(REG_CTRL, 32'h7);
    chk(32'(br), 32'(RESP_OKAY));
    s_axi_wstrb <= 4'hf;
    rdr(REG_CTRL);
    chk(rd, 32'h0);
    wr(5'h14, 32'h0);
    chk(32'(br), 32'(RESP_SLVERR));
    wr(REG_EVEN, 32'hf);
    wr(REG_CTRL, 32'h6);
    @(posedge ref_clk);
    watchdogOverflow <= 1'b1;
    @(posedge ref_clk);
    watchdogOverflow <= 1'b0;
    holdLen();
    lenChk(SST_LONG_CYCLES);
    state({CAUSE_WATCHDOG_RUN, 2'b10});
    rdr(REG_STATUS);
    chk(rd, (32'h1 << STATUS_TO_BIT) |
        (32'(CAUSE_WATCHDOG_RUN) << STATUS_CAUSE_LSB));
    rdr(REG_EVENT);
    chk(32'(rd[2]), 32'h1);
    chk(32'(irq), 32'h1);
    wr(REG_EVCLR, 32'hf);
    wr(REG_EVEN, 32'h0);
    chk(32'(irq), 32'h0);
    wr(REG_CTRL, 32'h4);
    haltExec <= 1'b1;
    sleepCmd <= 1'b1;
    @(posedge ref_clk);
    haltExec <= 1'b0;
    sleepCmd <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk(32'({flags, coreSleeping}), 32'h3);
    watchdogOverflow <= 1'b1;
    @(posedge ref_clk);
    watchdogOverflow <= 1'b0;
    for (n = 0; n < 50 && !rstCtl.wakeCore; n++) @(posedge ref_clk);
    chk(32'(n >= SST_SHORT_CYCLES && n <= SST_SHORT_CYCLES + 6), 32'h1);
    state({CAUSE_WATCHDOG_SLEEP, 2'b11});
    repeat (2) @(posedge ref_clk);
    chk(32'({irq, coreSleeping, pc < 8'h08}), 32'h1);
    wr(REG_EVEN, 32'hf);
    @(posedge ref_clk);
    chk(32'(irq), 32'h1);
    for (int i = 0; i < 2; i++) begin
      if (i == 1) wr(REG_CTRL, 32'h7);
      @(posedge ref_clk);
      if (i == 0) extResetPin_n <= 1'b0;
      else lowVoltageReset <= 1'b1;
      repeat (5) @(posedge ref_clk);
      extResetPin_n <= 1'b1;
      lowVoltageReset <= 1'b0;
      holdLen();
      lenChk(i == 0 ? SST_SHORT_CYCLES : SST_LONG_CYCLES);
      state({CAUSE_PIN_OR_LOW_VOLTAGE, 2'b11});
    end
    wr(REG_CTRL, 32'h5);
    clrWdtExec <= 1'b1;
    @(posedge ref_clk);
    clrWdtExec <= 1'b0;
    haltExec <= 1'b1;
    @(posedge ref_clk);
    haltExec <= 1'b0;
    porDetect <= 1'b1;
    extResetPin_n <= 1'b0;
    repeat (5) @(posedge ref_clk);
    porDetect <= 1'b0;
    extResetPin_n <= 1'b1;
    holdLen();
    lenChk(SST_SHORT_CYCLES);
    state({CAUSE_POWER_ON, 2'b00});
    give_verdict();
  end

  initial begin
    #100000;
    failures++;
    give_verdict();
  end
endmodule
